// ---- src/atr_timer.sv ----
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module atr_timer #(
  parameter int SYNC_EDGES = atr_pkg::SYNC_EDGES
) (
  input  wire logic        CLOCK_I,          // 250 MHz system clock
  input  wire logic        RST_N_I,          // Sync reset, active low
  input  wire logic [11:0] S_AXI_AWADDR_I,   // Write address
  input  wire logic        S_AXI_AWVALID_I,  // Write address valid
  output logic             S_AXI_AWREADY_O,  // Write address ready
  input  wire logic [31:0] S_AXI_WDATA_I,    // Write data
  input  wire logic [3:0]  S_AXI_WSTRB_I,    // Byte strobes
  input  wire logic        S_AXI_WVALID_I,   // Write data valid
  output logic             S_AXI_WREADY_O,   // Write data ready
  output logic [1:0]       S_AXI_BRESP_O,    // Write response
  output logic             S_AXI_BVALID_O,   // Write response valid
  input  wire logic        S_AXI_BREADY_I,   // Write response ready
  input  wire logic [11:0] S_AXI_ARADDR_I,   // Read address
  input  wire logic        S_AXI_ARVALID_I,  // Read address valid
  output logic             S_AXI_ARREADY_O,  // Read address ready
  output logic [31:0]      S_AXI_RDATA_O,    // Read data
  output logic [1:0]       S_AXI_RRESP_O,    // Read response
  output logic             S_AXI_RVALID_O,   // Read data valid
  input  wire logic        S_AXI_RREADY_I,   // Read data ready
  input  wire logic        TIMER_OSC_I,      // Async timer clock level
  input  wire logic        GLOBAL_IE_I,      // cpu_status_word global enable
  input  wire logic [2:0]  VECTOR_ACK_I,     // Vector executed, per flag
  output logic             EXT_CLK_BUF_EN_O, // External clock buffer on
  output logic             OSC_EN_O,         // Crystal oscillator runs
  output logic             WAVE_OUT_A_O,     // Compare A waveform
  output logic             WAVE_OUT_B_O,     // Compare B waveform
  output logic             SYNC_PSR_O,       // Shared prescaler reset
  output logic             IRQ_O             // Level interrupt
);

  if (SYNC_EDGES < 1 || SYNC_EDGES > 15) begin : g_chk
    $error("SYNC_EDGES out of range");
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        aw_held_q, w_held_q;
  logic [9:0]  aw_idx_q, ar_idx;
  logic [7:0]  wbyte_q;
  logic        wstrb0_q;
  logic        wr_go, wr_en, wr_hit;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  // Register state
  logic        ext_clk_q, async_sel_q;
  logic [2:0]  mask_q, flags_q;
  logic        sync_mode_q, psr_asy_q, psr_sync_q;
  logic [7:0]  cnt_q;
  logic        down_q, supp_q, osc_q;

  // Slot wiring
  logic [atr_pkg::NUM_SLOTS-1:0] slot_wr, slot_busy, slot_load;
  logic [7:0] slot_temp [atr_pkg::NUM_SLOTS];
  logic [7:0] slot_live [atr_pkg::NUM_SLOTS];

  // Both halves of a write must have arrived before it is applied
  assign wr_go = aw_held_q && w_held_q && !S_AXI_BVALID_O;
  assign wr_en = wr_go && wstrb0_q;
  assign ar_idx = S_AXI_ARADDR_I[11:2];

  // Write address and data capture, in either order
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      aw_held_q       <= 1'b0;
      w_held_q        <= 1'b0;
      aw_idx_q        <= '0;
      wbyte_q         <= atr_pkg::RST_BYTE;
      wstrb0_q        <= 1'b0;
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O  <= 1'b1;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held_q       <= 1'b1;
        aw_idx_q        <= S_AXI_AWADDR_I[11:2];
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held_q       <= 1'b1;
        wbyte_q        <= S_AXI_WDATA_I[7:0];
        wstrb0_q       <= S_AXI_WSTRB_I[0];
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O  <= 1'b1;
      end
    end
  end

  // Write decode; unmapped offsets answer SLVERR
  always_comb begin
    wr_hit  = 1'b1;
    slot_wr = '0;
    if (aw_idx_q == atr_pkg::IDX_COUNTER) begin
      slot_wr[atr_pkg::SLOT_CNT] = wr_en;
    end else if (aw_idx_q == atr_pkg::IDX_CMP_A) begin
      slot_wr[atr_pkg::SLOT_CMPA] = wr_en;
    end else if (aw_idx_q == atr_pkg::IDX_CMP_B) begin
      slot_wr[atr_pkg::SLOT_CMPB] = wr_en;
    end else if (aw_idx_q == atr_pkg::IDX_CTRL_A) begin
      slot_wr[atr_pkg::SLOT_CTLA] = wr_en;
    end else if (aw_idx_q == atr_pkg::IDX_CTRL_B) begin
      slot_wr[atr_pkg::SLOT_CTLB] = wr_en;
    end else if (aw_idx_q != atr_pkg::IDX_GEN_CTRL && aw_idx_q != atr_pkg::IDX_IRQ_MASK
                 && aw_idx_q != atr_pkg::IDX_ASYNC_ST && aw_idx_q != atr_pkg::IDX_IRQ_FLAGS) begin
      wr_hit = 1'b0;
    end
  end

  // Write response
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= atr_pkg::RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= wr_hit ? atr_pkg::RESP_OKAY : atr_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // read mux, live counter but stored copies elsewhere
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = atr_pkg::RST_BYTE;
    if (ar_idx == atr_pkg::IDX_COUNTER) begin
      rd_byte = cnt_q;
    end else if (ar_idx == atr_pkg::IDX_CMP_A) begin
      rd_byte = slot_temp[atr_pkg::SLOT_CMPA];
    end else if (ar_idx == atr_pkg::IDX_CMP_B) begin
      rd_byte = slot_temp[atr_pkg::SLOT_CMPB];
    end else if (ar_idx == atr_pkg::IDX_CTRL_A) begin
      rd_byte = slot_temp[atr_pkg::SLOT_CTLA] & atr_pkg::CTLA_MASK;
    end else if (ar_idx == atr_pkg::IDX_CTRL_B) begin
      rd_byte = slot_temp[atr_pkg::SLOT_CTLB] & atr_pkg::CTLB_MASK;
    end else if (ar_idx == atr_pkg::IDX_ASYNC_ST) begin
      rd_byte = {1'b0, ext_clk_q, async_sel_q, slot_busy};
    end else if (ar_idx == atr_pkg::IDX_IRQ_MASK) begin
      rd_byte = {5'h00, mask_q};
    end else if (ar_idx == atr_pkg::IDX_IRQ_FLAGS) begin
      rd_byte = {5'h00, flags_q};
    end else if (ar_idx == atr_pkg::IDX_GEN_CTRL) begin
      rd_byte = {sync_mode_q, 5'h00, psr_asy_q, psr_sync_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel, data one cycle after the address is taken
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= '0;
      S_AXI_RRESP_O   <= atr_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b1;
      S_AXI_RDATA_O   <= {24'h000000, rd_byte};
      S_AXI_RRESP_O   <= rd_hit ? atr_pkg::RESP_OKAY : atr_pkg::RESP_SLVERR;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  logic osc_rise, tick, run;

  // Pin is already synchronous, so one stage finds the edge
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= TIMER_OSC_I;
    end
  end
  assign osc_rise = TIMER_OSC_I && !osc_q;

  assign tick = async_sel_q ? osc_rise : 1'b1;
  // Async prescaler reset (psr_asy_q) halts counting while asserted
  assign run  = (slot_live[atr_pkg::SLOT_CTLB][2:0] != atr_pkg::CS_STOPPED) && !psr_asy_q;

  // async_status bits; software is expected to set ext first
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ext_clk_q   <= 1'b0;
      async_sel_q <= 1'b0;
    end else if (wr_en && aw_idx_q == atr_pkg::IDX_ASYNC_ST) begin
      ext_clk_q   <= wbyte_q[atr_pkg::BIT_EXT_CLK];
      async_sel_q <= wbyte_q[atr_pkg::BIT_ASYNC_SEL];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      EXT_CLK_BUF_EN_O <= 1'b0;
      OSC_EN_O         <= 1'b0;
    end else begin
      EXT_CLK_BUF_EN_O <= ext_clk_q && async_sel_q;
      OSC_EN_O         <= async_sel_q && !ext_clk_q;
    end
  end

  // ----------------------------------------------------------------
  // Cross-boundary register slots
  // ----------------------------------------------------------------
  for (genvar s = 0; s < atr_pkg::NUM_SLOTS; s++) begin : g_slot
    atr_update_slot #(
      .WIDTH (8),
      .EDGES (SYNC_EDGES)
    ) u_slot (
      .clk_i   (CLOCK_I),
      .rst_n_i (RST_N_I),
      .wr_i    (slot_wr[s]),
      .wdata_i (wbyte_q),
      .async_i (async_sel_q),
      .tick_i  (osc_rise),
      .temp_o  (slot_temp[s]),
      .live_o  (slot_live[s]),
      .busy_o  (slot_busy[s]),
      .load_o  (slot_load[s])
    );
  end

  // ----------------------------------------------------------------
  // Counter and events
  // ----------------------------------------------------------------
  logic dual, ovf_ev, cmpa_ev, cmpb_ev, step;

  assign dual = slot_live[atr_pkg::SLOT_CTLA][1:0] == atr_pkg::MODE_DUAL
                && !slot_live[atr_pkg::SLOT_CTLB][atr_pkg::BIT_DUAL_MSB];
  assign step = tick && run && !slot_load[atr_pkg::SLOT_CNT];

  // wrap in single slope, bottom turn in dual slope
  assign ovf_ev = step && (dual ? (down_q && cnt_q == atr_pkg::CNT_BOTTOM)
                                : (cnt_q == atr_pkg::CNT_MAX));
  assign cmpa_ev = step && !supp_q && cnt_q == slot_live[atr_pkg::SLOT_CMPA];
  assign cmpb_ev = step && !supp_q && cnt_q == slot_live[atr_pkg::SLOT_CMPB];

  // Counter update; a loaded value wins over counting
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      cnt_q  <= atr_pkg::RST_BYTE;
      down_q <= 1'b0;
    end else if (slot_load[atr_pkg::SLOT_CNT]) begin
      cnt_q <= slot_live[atr_pkg::SLOT_CNT];
    end else if (step) begin
      if (!dual) begin
        down_q <= 1'b0;
        cnt_q  <= cnt_q + atr_pkg::CNT_ONE;
      end else if (down_q) begin
        down_q <= cnt_q != atr_pkg::CNT_BOTTOM;
        cnt_q  <= (cnt_q == atr_pkg::CNT_BOTTOM) ? atr_pkg::CNT_ONE : cnt_q - atr_pkg::CNT_ONE;
      end else begin
        down_q <= cnt_q == atr_pkg::CNT_MAX;
        cnt_q  <= (cnt_q == atr_pkg::CNT_MAX) ? cnt_q - atr_pkg::CNT_ONE : cnt_q + atr_pkg::CNT_ONE;
      end
    end
  end

  // suppression lasts until the next timer clock
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      supp_q <= 1'b0;
    end else if (slot_load[atr_pkg::SLOT_CNT]) begin
      supp_q <= 1'b1;
    end else if (tick && run) begin
      supp_q <= 1'b0;
    end
  end

  // Waveform toggles on match when enabled
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      WAVE_OUT_A_O <= 1'b0;
      WAVE_OUT_B_O <= 1'b0;
    end else begin
      if (cmpa_ev && slot_live[atr_pkg::SLOT_CTLA][atr_pkg::BIT_TOG_A]) begin
        WAVE_OUT_A_O <= !WAVE_OUT_A_O;
      end
      if (cmpb_ev && slot_live[atr_pkg::SLOT_CTLA][atr_pkg::BIT_TOG_B]) begin
        WAVE_OUT_B_O <= !WAVE_OUT_B_O;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [2:0] ev_set, w1c;

  assign ev_set = {cmpb_ev, cmpa_ev, ovf_ev};
  assign w1c    = (wr_en && aw_idx_q == atr_pkg::IDX_IRQ_FLAGS) ? wbyte_q[2:0] : 3'h0;

  // cleared by vector or write one; set wins
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= ev_set | (flags_q & ~(w1c | VECTOR_ACK_I));
    end
  end

  // Mask register
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      mask_q <= 3'h0;
    end else if (wr_en && aw_idx_q == atr_pkg::IDX_IRQ_MASK) begin
      mask_q <= wbyte_q[2:0] & atr_pkg::IRQ_MASK3;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= GLOBAL_IE_I && |(flags_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Prescaler reset and synchronization mode
  // ----------------------------------------------------------------
  logic gen_wr;
  assign gen_wr = wr_en && aw_idx_q == atr_pkg::IDX_GEN_CTRL;

  // sync mode holds, leaving it clears both
  // async reset waits for a timer edge in async mode
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      sync_mode_q <= 1'b0;
      psr_asy_q   <= 1'b0;
      psr_sync_q  <= 1'b0;
    end else if (gen_wr) begin
      sync_mode_q <= wbyte_q[atr_pkg::BIT_SYNC_MODE];
      psr_asy_q   <= wbyte_q[atr_pkg::BIT_SYNC_MODE] && wbyte_q[atr_pkg::BIT_PSR_ASY]
                     || wbyte_q[atr_pkg::BIT_PSR_ASY] && async_sel_q;
      psr_sync_q  <= wbyte_q[atr_pkg::BIT_SYNC_MODE] && wbyte_q[atr_pkg::BIT_PSR_SYNC];
    end else if (!sync_mode_q) begin
      psr_sync_q <= 1'b0;
      if (!async_sel_q || osc_rise) begin
        psr_asy_q <= 1'b0;
      end
    end
  end

  // Shared reset pulse reaches the other timers
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      SYNC_PSR_O <= 1'b0;
    end else begin
      SYNC_PSR_O <= psr_sync_q || (gen_wr && wbyte_q[atr_pkg::BIT_PSR_SYNC]);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_async_cnt_write;
    async_sel_q && slot_wr[atr_pkg::SLOT_CNT];
  endsequence

  chk_busy_set_on_write: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_async_cnt_write |=> slot_busy[atr_pkg::SLOT_CNT]) else $error("busy not set");

  chk_busy_clear_on_load: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $fell(slot_busy[atr_pkg::SLOT_CMPA]) |-> slot_load[atr_pkg::SLOT_CMPA])
    else $error("busy fell without load");

  chk_ext_buffer_enable: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ##1 EXT_CLK_BUF_EN_O == $past(ext_clk_q && async_sel_q)
    && (OSC_EN_O -> !$past(ext_clk_q))) else $error("clock enable wrong");

  chk_irq_level_gate: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ##1 IRQ_O == $past(GLOBAL_IE_I && |(flags_q & mask_q))) else $error("irq mismatch");

  chk_flag_set_wins: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    cmpa_ev && w1c[atr_pkg::BIT_CMP_A] |=> flags_q[atr_pkg::BIT_CMP_A])
    else $error("set lost to clear");

  chk_flag_w1c_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    w1c[atr_pkg::BIT_OVF] && !ovf_ev |=> !flags_q[atr_pkg::BIT_OVF])
    else $error("flag not cleared");

  chk_match_sets_flag: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    step && !supp_q && cnt_q == slot_live[atr_pkg::SLOT_CMPB] |=> flags_q[atr_pkg::BIT_CMP_B])
    else $error("compare flag missing");

  sequence s_cnt_loaded;
    slot_load[atr_pkg::SLOT_CNT] ##1 (tick && run);
  endsequence

  chk_suppress_next_tick: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_cnt_loaded |-> !cmpa_ev && !cmpb_ev) else $error("match not blocked");

  chk_sync_psr_selfclear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    psr_sync_q && !sync_mode_q && !gen_wr |=> !psr_sync_q) else $error("reset stuck");

  chk_tsm_holds_resets: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    sync_mode_q && psr_asy_q && !gen_wr |=> psr_asy_q) else $error("reset dropped");

  chk_ovf_at_wrap: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    step && !dual && cnt_q == atr_pkg::CNT_MAX |=> flags_q[atr_pkg::BIT_OVF]
    && cnt_q == atr_pkg::CNT_BOTTOM) else $error("overflow wrong");

endmodule : atr_timer

`default_nettype wire

// ---- src/atr_pkg.sv ----
package atr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_GEN_CTRL  = 10'h043;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h070;
  localparam logic [9:0] IDX_CTRL_A    = 10'h0B0;
  localparam logic [9:0] IDX_CTRL_B    = 10'h0B1;
  localparam logic [9:0] IDX_COUNTER   = 10'h0B2;
  localparam logic [9:0] IDX_CMP_A     = 10'h0B3;
  localparam logic [9:0] IDX_CMP_B     = 10'h0B4;
  localparam logic [9:0] IDX_ASYNC_ST  = 10'h0B6;
  localparam logic [9:0] IDX_IRQ_FLAGS = 10'h037;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_EXT_CLK   = 6;  // async_status
  localparam int BIT_ASYNC_SEL = 5;
  localparam int BIT_SYNC_MODE = 7;  // timer_general_control
  localparam int BIT_PSR_ASY   = 1;
  localparam int BIT_PSR_SYNC  = 0;
  localparam int BIT_CMP_B     = 2;  // mask and flags
  localparam int BIT_CMP_A     = 1;
  localparam int BIT_OVF       = 0;
  localparam int BIT_TOG_A     = 6;  // control_reg_a toggle enables
  localparam int BIT_TOG_B     = 4;
  localparam int BIT_DUAL_MSB  = 3;  // control_reg_b mode high bit

  // Busy flag order inside async_status
  localparam int SLOT_CNT  = 4;
  localparam int SLOT_CMPA = 3;
  localparam int SLOT_CMPB = 2;
  localparam int SLOT_CTLA = 1;
  localparam int SLOT_CTLB = 0;
  localparam int NUM_SLOTS = 5;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] CNT_MAX     = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM  = 8'h00;
  localparam logic [7:0] CNT_ONE     = 8'h01;
  localparam logic [7:0] CTLA_MASK   = 8'hF3;
  localparam logic [7:0] CTLB_MASK   = 8'h0F;
  localparam logic [2:0] IRQ_MASK3   = 3'h7;
  localparam logic [1:0] MODE_DUAL   = 2'h1;
  localparam logic [2:0] CS_STOPPED  = 3'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         SYNC_EDGES  = 2;

endpackage : atr_pkg

// ---- src/atr_update_slot.sv ----
`timescale 1ns/1ps
`default_nettype none

// Temporary storage plus live copy for one register written across the
// timer clock boundary; busy stands until the live copy is loaded.
module atr_update_slot #(
  parameter int WIDTH = 8,
  parameter int EDGES = atr_pkg::SYNC_EDGES
) (
  input  wire logic             clk_i,    // System clock
  input  wire logic             rst_n_i,  // Sync reset, active low
  input  wire logic             wr_i,     // Software write strobe
  input  wire logic [WIDTH-1:0] wdata_i,  // Written value
  input  wire logic             async_i,  // Timer runs from async clock
  input  wire logic             tick_i,   // Async timer clock edge
  output logic      [WIDTH-1:0] temp_o,   // Temporary storage
  output logic      [WIDTH-1:0] live_o,   // Live register
  output logic                  busy_o,   // Update busy flag
  output logic                  load_o    // Live loaded this cycle
);

  localparam logic [3:0] LAST = 4'(EDGES - 1);
  logic [3:0] edge_q;

  if (EDGES < 1 || EDGES > 15) begin : g_chk
    $error("EDGES out of range");
  end

  // Temporary storage takes every write at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      temp_o <= '0;
    end else if (wr_i) begin
      temp_o <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      live_o <= '0;
      busy_o <= 1'b0;
      load_o <= 1'b0;
      edge_q <= '0;
    end else begin
      load_o <= 1'b0;
      if (wr_i) begin
        edge_q <= '0;
        if (async_i) begin
          busy_o <= 1'b1;
        end else begin
          live_o <= wdata_i;
          load_o <= 1'b1;
        end
      end else if (busy_o && tick_i) begin
        if (edge_q == LAST) begin
          live_o <= temp_o;
          busy_o <= 1'b0;
          load_o <= 1'b1;
        end else begin
          edge_q <= edge_q + 4'h1;
        end
      end
    end
  end

endmodule : atr_update_slot

`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic        osc = 1'b0, gie = 1'b0;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [2:0]  ack = '0;
  logic [1:0]  br, rr, resp;
  logic        awr, wrdy, bv, arr, rv, ext_en, osc_en, irq, spsr, wa, wb;
  int          num_errors = 0, compares = 0;
  // Free-running clock, 4 ns period
  always #2 clk = ~clk;
  atr_timer dut (.CLOCK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1), .TIMER_OSC_I(osc),
    .GLOBAL_IE_I(gie), .VECTOR_ACK_I(ack), .EXT_CLK_BUF_EN_O(ext_en), .OSC_EN_O(osc_en),
    .WAVE_OUT_A_O(wa), .WAVE_OUT_B_O(wb), .SYNC_PSR_O(spsr), .IRQ_O(irq));
  // ----------------------------------------------------------------
  // Bus tasks; address and data held until each channel is taken
  // ----------------------------------------------------------------
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    awa <= {i, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    resp = br;
  endtask : wr
  task automatic rc(input logic [9:0] i, input logic [7:0] e);
    ara <= {i, 2'h0};
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    resp = rr;
    `CHK(rd, {24'h0, e})
  endtask : rc
  // Registered outputs lag a cycle; ending on a rising edge keeps stimulus aligned
  task automatic st;
    repeat (3) @(posedge clk);
  endtask : st
  task automatic tick;
    @(posedge clk) osc <= 1'b1;
    repeat (2) @(posedge clk);
    osc <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : tick
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rc(atr_pkg::IDX_GEN_CTRL, 8'h00);
    rc(atr_pkg::IDX_IRQ_MASK, 8'h00);
    rc(atr_pkg::IDX_ASYNC_ST, 8'h00);
    `CHK(resp, atr_pkg::RESP_OKAY)
    rc(10'h000, 8'h00);
    `CHK(resp, atr_pkg::RESP_SLVERR)
    wr(10'h000, 8'hFF);
    `CHK(resp, atr_pkg::RESP_SLVERR)
    wr(atr_pkg::IDX_CMP_B, 8'hA5);
    rc(atr_pkg::IDX_CMP_B, 8'hA5);
    wr(atr_pkg::IDX_IRQ_MASK, 8'hFF);
    rc(atr_pkg::IDX_IRQ_MASK, 8'h07);
  endtask : t_reset
  task automatic t_async;
    wr(atr_pkg::IDX_ASYNC_ST, 8'h20);
    st();
    `CHK({osc_en, ext_en}, 2'h2)
    wr(atr_pkg::IDX_CMP_A, 8'h3C);
    rc(atr_pkg::IDX_ASYNC_ST, 8'h28);
    rc(atr_pkg::IDX_CMP_A, 8'h3C);
    tick();
    tick();
    rc(atr_pkg::IDX_ASYNC_ST, 8'h20);
    wr(atr_pkg::IDX_ASYNC_ST, 8'h00);
    wr(atr_pkg::IDX_ASYNC_ST, 8'h40);
    wr(atr_pkg::IDX_ASYNC_ST, 8'h60);
    st();
    `CHK({osc_en, ext_en}, 2'h1)
    wr(atr_pkg::IDX_ASYNC_ST, 8'h00);
    wr(atr_pkg::IDX_CMP_A, 8'h05);
    rc(atr_pkg::IDX_ASYNC_ST, 8'h00);
  endtask : t_async
  task automatic t_irq;
    gie <= 1'b1;
    wr(atr_pkg::IDX_IRQ_MASK, 8'h02);
    wr(atr_pkg::IDX_CTRL_A, 8'h50);
    wr(atr_pkg::IDX_CTRL_B, 8'h01);
    repeat (300) @(posedge clk);
    wr(atr_pkg::IDX_CTRL_B, 8'h00);
    // Counts 0 to 0xFF, wraps and ends at 0x2F: match A twice, match B once
    `CHK({wa, wb}, 2'h1)
    rc(atr_pkg::IDX_IRQ_FLAGS, 8'h07);
    `CHK(irq, 1'b1)
    wr(atr_pkg::IDX_IRQ_FLAGS, 8'h02);
    rc(atr_pkg::IDX_IRQ_FLAGS, 8'h05);
    st();
    `CHK(irq, 1'b0)
    @(posedge clk) ack <= 3'h1;
    @(posedge clk) ack <= 3'h0;
    rc(atr_pkg::IDX_IRQ_FLAGS, 8'h04);
    wr(atr_pkg::IDX_IRQ_MASK, 8'h04);
    st();
    `CHK(irq, 1'b1)
    gie <= 1'b0;
    st();
    `CHK(irq, 1'b0)
  endtask : t_irq
  // Counter load while running blocks the match at the loaded value
  task automatic t_block;
    wr(atr_pkg::IDX_IRQ_FLAGS, 8'h07);
    wr(atr_pkg::IDX_CTRL_B, 8'h01);
    wr(atr_pkg::IDX_COUNTER, 8'hA5);
    st();
    wr(atr_pkg::IDX_CTRL_B, 8'h00);
    rc(atr_pkg::IDX_COUNTER, 8'hAA);
    rc(atr_pkg::IDX_IRQ_FLAGS, 8'h00);
    `CHK({wa, wb}, 2'h1)
  endtask : t_block
  task automatic t_psr;
    wr(atr_pkg::IDX_GEN_CTRL, 8'h83);
    rc(atr_pkg::IDX_GEN_CTRL, 8'h83);
    `CHK(spsr, 1'b1)
    wr(atr_pkg::IDX_GEN_CTRL, 8'h03);
    rc(atr_pkg::IDX_GEN_CTRL, 8'h00);
    wr(atr_pkg::IDX_GEN_CTRL, 8'h02);
    rc(atr_pkg::IDX_GEN_CTRL, 8'h00);
    st();
    `CHK(spsr, 1'b0)
  endtask : t_psr
  task automatic conclude;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // Main sequence after a 16 cycle reset
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_async();
    t_irq();
    t_block();
    t_psr();
    conclude();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
